// file: hdl/coasting_motor_speed_search.sv
`timescale 1ns/1ps
// How it works
// - input code 61/62/64 picks search start
// - selection 0: run ramps from minimum frequency
// - selection 1: search, or ramp from encoder
// - selection honoured only for methods 1, 3
// - threshold 0..200 percent, default 150
// - ramp down until current below threshold
// - default threshold 150 v/f, 100 open vector
// - decel time 0.1..10.0 s, default 2.0
// - decel time zero disables search
// - run before search ignores search
module coasting_motor_speed_search #(
   parameter int TICK_CYCLES = speed_search_pkg::TICK_CYCLES // cycles per 0.1 s
) (
   input  wire logic        core_clk,                    // 125 MHz control clock
   input  wire logic        rst_n,                       // async reset, active low
   input  wire logic        forward_run_command,         // forward run contact
   input  wire logic        reverse_run_command,         // reverse run contact
   input  wire logic        searchContact,               // search contact input
   input  wire logic [7:0]  multi_input_function_select, // function code of search input
   input  wire logic [1:0]  control_method_select,       // control method
   input  wire logic        search_at_start_select,      // search after run enable
   input  wire logic        thresholdLoad,               // pulse: load user threshold
   input  wire logic [7:0]  thresholdIn,                 // user threshold, percent
   input  wire logic [6:0]  search_decel_time,           // tenths of a second
   input  wire logic        encoderFitted,               // encoder feedback present
   input  wire logic [15:0] encoderFreq,                 // measured motor speed
   input  wire logic [15:0] maxFreq,                     // maximum output frequency
   input  wire logic [15:0] setFreq,                     // set frequency
   input  wire logic [15:0] minFreq,                     // minimum frequency reference
   input  wire logic [15:0] ramp_generator,              // ramp generator frequency
   input  wire logic        outputBlocked,               // output blocked
   input  wire logic [7:0]  outputCurrentPct,            // output current, percent
   output logic [15:0]      outFreq,                     // output frequency command
   output logic             searching,                   // search in progress
   output logic             speedAgree,                  // pulse: agree point found
   output logic [7:0]       search_current_threshold     // threshold in use
);
   localparam int FW = speed_search_pkg::FREQ_W; // frequency width

   logic fwdF;            // filtered forward
   logic revF;            // filtered reverse
   logic srchF;           // filtered search
   logic runNow;          // any run command
   logic runPrev;         // run last cycle
   logic searchArmed;     // search seen before run
   logic [31:0] tickCnt;  // 0.1 s prescaler
   logic tick;            // 0.1 s strobe
   logic [6:0] stepCnt;   // ticks since last decrement
   logic decelEnable;     // decel time nonzero and legal
   logic methodOk;        // method honours selection
   logic useSearch;       // search for this run
   logic [FW-1:0] startFreq; // chosen search start
   logic codeValid;       // input code is a search code
   logic methodPrev;      // tracks method changes
   speed_search_pkg::seq_state_t state; // sequencer state

   // contact inputs cross from the pins
   input_filter uFwd (.core_clk(core_clk), .rst_n(rst_n), .pinIn(forward_run_command), .pinOut(fwdF));
   input_filter uRev (.core_clk(core_clk), .rst_n(rst_n), .pinIn(reverse_run_command), .pinOut(revF));
   input_filter uSrch (.core_clk(core_clk), .rst_n(rst_n), .pinIn(searchContact), .pinOut(srchF));

   assign runNow = fwdF | revF;
   assign methodOk = (control_method_select == speed_search_pkg::CTRL_VF_ENC) ||
                     (control_method_select == speed_search_pkg::CTRL_CLV);
   assign decelEnable = (search_decel_time != 7'h00) &&
                        (search_decel_time <= speed_search_pkg::DECEL_MAX_TENTHS);
   assign codeValid = (multi_input_function_select == speed_search_pkg::FUNC_SEARCH_FROM_MAX) ||
                      (multi_input_function_select == speed_search_pkg::FUNC_SEARCH_FROM_SET) ||
                      (multi_input_function_select == speed_search_pkg::FUNC_SEARCH_FROM_RAMP);
   assign useSearch = methodOk && (search_at_start_select == speed_search_pkg::SEARCH_AT_START_ON);

   // start point by input assignment code
   always_comb
   begin
      unique case (multi_input_function_select)
         speed_search_pkg::FUNC_SEARCH_FROM_MAX: startFreq = maxFreq;
         speed_search_pkg::FUNC_SEARCH_FROM_SET: startFreq = setFreq;
         speed_search_pkg::FUNC_SEARCH_FROM_RAMP: startFreq = outputBlocked ? ramp_generator : setFreq;
         default: startFreq = maxFreq; // unused when code invalid
      endcase
   end

   // run edge tracking
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         runPrev <= 1'b0;
      else
         runPrev <= runNow;
   end

   // arm search only while run is off; a late search stays ignored
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         searchArmed <= 1'b0;
      else if (!runNow)
         searchArmed <= srchF; // search before run
      else if (state != speed_search_pkg::ST_IDLE)
         searchArmed <= 1'b0; // consumed for this run
   end

   // 0.1 s prescaler, runs only while searching
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         tickCnt <= '0;
      else if (state != speed_search_pkg::ST_SEARCH || tickCnt == 32'(TICK_CYCLES - 1))
         tickCnt <= '0;
      else
         tickCnt <= tickCnt + 32'h1;
   end
   assign tick = (state == speed_search_pkg::ST_SEARCH) && (tickCnt == 32'(TICK_CYCLES - 1));

   // step the frequency once per decel time setting
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         stepCnt <= '0;
      else if (state != speed_search_pkg::ST_SEARCH)
         stepCnt <= '0;
      else if (tick)
         stepCnt <= (stepCnt + 7'h1 >= search_decel_time) ? 7'h00 : stepCnt + 7'h1;
   end

   // detection threshold; default follows control method
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         search_current_threshold <= speed_search_pkg::THRESH_DEF_VF;
         methodPrev <= 1'b0;
      end
      else if (thresholdLoad && thresholdIn <= speed_search_pkg::THRESH_MAX_PCT)
         search_current_threshold <= thresholdIn; // user value, range checked
      else
      begin
         methodPrev <= (control_method_select == speed_search_pkg::CTRL_OLV);
         if ((control_method_select == speed_search_pkg::CTRL_OLV) != methodPrev)
            search_current_threshold <= (control_method_select == speed_search_pkg::CTRL_OLV) ?
               speed_search_pkg::THRESH_DEF_OLV : speed_search_pkg::THRESH_DEF_VF;
      end
   end

   // sequencer and output frequency
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= speed_search_pkg::ST_IDLE;
         outFreq <= '0;
         speedAgree <= 1'b0;
      end
      else
      begin
         speedAgree <= 1'b0;
         unique case (state)
            speed_search_pkg::ST_IDLE:
            begin
               outFreq <= '0;
               if (runNow && !runPrev)
               begin
                  if (useSearch && encoderFitted)
                  begin
                     outFreq <= encoderFreq; // ramp from motor speed
                     state <= speed_search_pkg::ST_RAMP;
                  end
                  else if (useSearch && (searchArmed || srchF) && codeValid && decelEnable) // with or before run
                  begin
                     outFreq <= startFreq;
                     state <= speed_search_pkg::ST_SEARCH;
                  end
                  else
                  begin
                     outFreq <= minFreq; // no search, from minimum
                     state <= speed_search_pkg::ST_RAMP;
                  end
               end
            end
            speed_search_pkg::ST_SEARCH:
            begin
               if (!runNow)
                  state <= speed_search_pkg::ST_IDLE;
               else if (outputCurrentPct < search_current_threshold)
               begin
                  speedAgree <= 1'b1; // agree point found
                  state <= speed_search_pkg::ST_RAMP; // back to normal ramp
               end
               else if (tick && stepCnt + 7'h1 >= search_decel_time && outFreq != '0)
                  outFreq <= outFreq - 16'h1; // ramp down
            end
            speed_search_pkg::ST_RAMP:
            begin
               if (!runNow)
                  state <= speed_search_pkg::ST_IDLE;
               else if (outFreq < setFreq)
                  outFreq <= outFreq + 16'h1; // toward set frequency
               else if (outFreq > setFreq)
                  outFreq <= outFreq - 16'h1;
            end
         endcase
      end
   end

   assign searching = (state == speed_search_pkg::ST_SEARCH);

   // search ends on agree within one cycle of low current
   property p_agree;
      @(posedge core_clk) disable iff (!rst_n)
      (searching && runNow && outputCurrentPct < search_current_threshold) |=> (speedAgree && !searching);
   endproperty
   a_agree: assert property (p_agree) else $error("agree missed");

   // no search starts with zero decel time
   property p_zero;
      @(posedge core_clk) disable iff (!rst_n)
      (!searching && search_decel_time == 7'h00) |=> !searching;
   endproperty
   a_zero: assert property (p_zero) else $error("search with zero decel");

   // no search in other control methods
   property p_method;
      @(posedge core_clk) disable iff (!rst_n)
      (!searching && !methodOk) |=> !searching;
   endproperty
   a_method: assert property (p_method) else $error("search in wrong method");

   // selection 0 starts from minimum frequency
   property p_nosel;
      @(posedge core_clk) disable iff (!rst_n)
      (state == speed_search_pkg::ST_IDLE && runNow && !runPrev && !search_at_start_select)
         |=> (state == speed_search_pkg::ST_RAMP && outFreq == $past(minFreq));
   endproperty
   a_nosel: assert property (p_nosel) else $error("no-search start wrong");

   // late search never starts a search
   property p_late;
      @(posedge core_clk) disable iff (!rst_n)
      (!searchArmed && !srchF && !searching) |=> !searching;
   endproperty
   a_late: assert property (p_late) else $error("late search accepted");

   // threshold never exceeds range
   property p_thr;
      @(posedge core_clk) disable iff (!rst_n)
      search_current_threshold <= speed_search_pkg::THRESH_MAX_PCT;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold out of range");

   // frequency never rises during search
   property p_down;
      @(posedge core_clk) disable iff (!rst_n)
      (searching ##1 searching) |-> outFreq <= $past(outFreq);
   endproperty
   a_down: assert property (p_down) else $error("search frequency rose");

   // agree returns to ramp, not search
   property p_clear;
      @(posedge core_clk) disable iff (!rst_n)
      speedAgree |-> (state == speed_search_pkg::ST_RAMP) ##1 !searching;
   endproperty
   a_clear: assert property (p_clear) else $error("search not cleared");

   // open loop vector change loads default 100
   property p_def;
      @(posedge core_clk) disable iff (!rst_n)
      (!thresholdLoad && control_method_select == speed_search_pkg::CTRL_OLV && !methodPrev)
         |=> search_current_threshold == speed_search_pkg::THRESH_DEF_OLV;
   endproperty
   a_def: assert property (p_def) else $error("default threshold wrong");
endmodule // coasting_motor_speed_search

// file: hdl/input_filter.sv
`timescale 1ns/1ps
// three-flop synchroniser; output changes when stages two and three agree
module input_filter (
   input  wire logic core_clk, // control clock
   input  wire logic rst_n,    // async reset, active low
   input  wire logic pinIn,    // raw contact input
   output logic      pinOut    // filtered level
);
   logic s1; // first stage, read only by s2
   logic s2; // second stage
   logic s3; // third stage

   // shift chain
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= pinIn;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // accept a change only when the two later stages agree
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pinOut <= 1'b0;
      else if (s2 == s3)
         pinOut <= s3;
   end
endmodule // input_filter

// file: pkg/speed_search_pkg.sv
package speed_search_pkg;
   // multi-function input assignment codes that start a search
   localparam logic [7:0] FUNC_SEARCH_FROM_MAX = 8'h3D; // 61
   localparam logic [7:0] FUNC_SEARCH_FROM_SET = 8'h3E; // 62
   localparam logic [7:0] FUNC_SEARCH_FROM_RAMP = 8'h40; // 64
   // control method codes
   localparam logic [1:0] CTRL_VF = 2'h0; // plain v/f
   localparam logic [1:0] CTRL_VF_ENC = 2'h1; // v/f with encoder
   localparam logic [1:0] CTRL_OLV = 2'h2; // open loop vector
   localparam logic [1:0] CTRL_CLV = 2'h3; // closed loop vector
   // threshold limits and defaults, percent of rated current
   localparam logic [7:0] THRESH_MAX_PCT = 8'hC8; // 200
   localparam logic [7:0] THRESH_DEF_VF = 8'h96; // 150
   localparam logic [7:0] THRESH_DEF_OLV = 8'h64; // 100
   // decel time limits, tenths of a second
   localparam logic [6:0] DECEL_MAX_TENTHS = 7'h64; // 10.0 s
   localparam logic [6:0] DECEL_DEF_TENTHS = 7'h14; // 2.0 s
   // one decel step is 0.1 s at 125 MHz
   localparam int TICK_MS = 100;
   localparam int CLK_KHZ = 125000;
   localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
   // frequency codes
   localparam int FREQ_W = 16;
   // search-at-start selection
   localparam logic SEARCH_AT_START_OFF = 1'h0;
   localparam logic SEARCH_AT_START_ON = 1'h1;
   // sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_RAMP} seq_state_t;
endpackage

// file: verif/coasting_motor_model.sv
`timescale 1ns/1ps
// coasting motor seen from the drive output: heavy current while overdriven
module coasting_motor_model (
   input  wire logic [15:0] outFreq,         // drive frequency command
   input  wire logic [15:0] motorSpeed,      // rotor speed, held by the bench
   output logic [7:0]       outputCurrentPct // current drawn, percent
);
   // rotor coasts slower than the search decel, so the bench holds it still
   always_comb
   begin
      if (outFreq > motorSpeed)
         outputCurrentPct = 8'hB4; // overdriven: above any default level
      else
         outputCurrentPct = 8'h28; // frequencies agree: low current
   end
endmodule // coasting_motor_model

// file: verif/test_coasting_motor_speed_search.sv
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      testsRun++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module test_coasting_motor_speed_search;
   localparam int TICK = 4; // shortened 0.1 s step
   typedef struct packed {logic [7:0] code; logic [1:0] method; logic sel; logic blocked; logic enc;
      logic [6:0] decel; logic expSearch; logic [15:0] expFreq;} row_t;
   logic        core_clk, rst_n, runFwd, runRev, searchContact, sel, thresholdLoad; // drive inputs
   logic        encoderFitted, outputBlocked, searching, speedAgree;               // mode and status
   logic [7:0]  code, thresholdIn, currentPct, threshold, expThr;                 // codes and percents
   logic [1:0]  method;                                                           // control method
   logic [6:0]  decel;                                                            // decel tenths
   logic [15:0] outFreq, motorSpeed;                                              // frequencies
   int          errors, testsRun, i, n;                                           // bench counters
   localparam logic [15:0] MAXF = 16'h0100, SETF = 16'h0080, MINF = 16'h0005, RAMPF = 16'h00C0, ENCF = 16'h0033;
   // rows: code, method, select, blocked, encoder, decel, search expected, first frequency
   row_t rows [10] = '{
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_VF_ENC, 1'h1, 1'h0, 1'h0, 7'h01, 1'h1, MAXF},
      {speed_search_pkg::FUNC_SEARCH_FROM_SET, speed_search_pkg::CTRL_CLV, 1'h1, 1'h0, 1'h0, 7'h64, 1'h1, SETF},
      {speed_search_pkg::FUNC_SEARCH_FROM_RAMP, speed_search_pkg::CTRL_VF_ENC, 1'h1, 1'h1, 1'h0, 7'h01, 1'h1, RAMPF},
      {speed_search_pkg::FUNC_SEARCH_FROM_RAMP, speed_search_pkg::CTRL_CLV, 1'h1, 1'h0, 1'h0, 7'h01, 1'h1, SETF},
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_VF, 1'h1, 1'h0, 1'h0, 7'h01, 1'h0, MINF},
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_OLV, 1'h1, 1'h0, 1'h0, 7'h01, 1'h0, MINF},
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_VF_ENC, 1'h0, 1'h0, 1'h0, 7'h01, 1'h0, MINF},
      {8'h13, speed_search_pkg::CTRL_VF_ENC, 1'h1, 1'h0, 1'h0, 7'h01, 1'h0, MINF},
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_CLV, 1'h1, 1'h0, 1'h0, 7'h00, 1'h0, MINF},
      {speed_search_pkg::FUNC_SEARCH_FROM_MAX, speed_search_pkg::CTRL_VF_ENC, 1'h1, 1'h0, 1'h1, 7'h01, 1'h0, ENCF}};

   // block under test, with a shortened 0.1 s step
   coasting_motor_speed_search #(
      .TICK_CYCLES(TICK)
   ) i_dut (
      .core_clk                    (core_clk),
      .rst_n                       (rst_n),
      .forward_run_command         (runFwd),
      .reverse_run_command         (runRev),
      .searchContact               (searchContact),
      .multi_input_function_select (code),
      .control_method_select       (method),
      .search_at_start_select      (sel),
      .thresholdLoad               (thresholdLoad),
      .thresholdIn                 (thresholdIn),
      .search_decel_time           (decel),
      .encoderFitted               (encoderFitted),
      .encoderFreq                 (ENCF),
      .maxFreq                     (MAXF),
      .setFreq                     (SETF),
      .minFreq                     (MINF),
      .ramp_generator              (RAMPF),
      .outputBlocked               (outputBlocked),
      .outputCurrentPct            (currentPct),
      .outFreq                     (outFreq),
      .searching                   (searching),
      .speedAgree                  (speedAgree),
      .search_current_threshold    (threshold)
   );

   // coasting motor at the drive output
   coasting_motor_model i_motor (
      .outFreq          (outFreq),
      .motorSpeed       (motorSpeed),
      .outputCurrentPct (currentPct)
   );

   // bench clock, 8 ns period
   always #4 core_clk = ~core_clk;

   // counts, then the verdict
   task automatic conclude;
      $display("errors %0d tests_run %0d", errors, testsRun);
      if (errors == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // let cnt rising edges pass, then stand just after the last one
   task automatic step(input int cnt);
      repeat (cnt) @(posedge core_clk);
      #1;
   endtask

   // wait for 0 a start frequency, 1 the agree pulse, 2 idle; edges counted in n
   task automatic wait_for(input int what, input int limit);
      logic hit;
      hit = 1'h0;
      n = 0;
      while (!hit && n < limit)
      begin
         @(posedge core_clk);
         #1;
         n++;
         if (what == 0)
            hit = (outFreq !== 16'h0000);
         else if (what == 1)
            hit = (speedAgree === 1'h1);
         else
            hit = (outFreq === 16'h0000) && (searching === 1'h0);
      end
      if (!hit)
      begin
         errors++;
         $display("mismatch at %0t: wait %0d ran out", $time, what);
         conclude();
      end
   endtask

   // hard limit on the whole run
   initial
   begin
      repeat (50000) @(posedge core_clk);
      errors++;
      $display("mismatch at %0t: run limit reached", $time);
      conclude();
   end

   // reset, table of start cases, then hand-written cases
   initial
   begin
      core_clk = 1'h0;
      rst_n = 1'h0;
      runFwd = 1'h0;
      runRev = 1'h0;
      searchContact = 1'h0;
      sel = 1'h0;
      thresholdLoad = 1'h0;
      thresholdIn = 8'h00;
      encoderFitted = 1'h0;
      outputBlocked = 1'h0;
      code = 8'h00;
      method = speed_search_pkg::CTRL_VF;
      decel = speed_search_pkg::DECEL_DEF_TENTHS;
      motorSpeed = 16'h0000;
      errors = 0;
      testsRun = 0;
      step(3);
      rst_n = 1'h1;
      step(2);
      `CHECK(outFreq, 16'h0000)
      `CHECK(searching, 1'h0)
      `CHECK(threshold, speed_search_pkg::THRESH_DEF_VF)
      // table rows: motor sits two steps below a searched start point
      for (i = 0; i < 10; i++)
      begin
         code = rows[i].code;
         method = rows[i].method;
         sel = rows[i].sel;
         outputBlocked = rows[i].blocked;
         encoderFitted = rows[i].enc;
         decel = rows[i].decel;
         motorSpeed = rows[i].expSearch ? rows[i].expFreq - 16'h2 : 16'h0000;
         expThr = (rows[i].method == speed_search_pkg::CTRL_OLV) ? speed_search_pkg::THRESH_DEF_OLV :
            speed_search_pkg::THRESH_DEF_VF;
         step(6);
         `CHECK(threshold, expThr)
         searchContact = 1'h1; // search raised ahead of run
         step(6);
         runFwd = 1'h1;
         wait_for(0, 20);
         `CHECK(searching, rows[i].expSearch)
         `CHECK(outFreq, rows[i].expFreq)
         if (rows[i].expSearch)
         begin
            wait_for(1, 2000);
            `CHECK(n, 2 * int'(rows[i].decel) * TICK + 1)
            `CHECK(outFreq, rows[i].expFreq - 16'h2)
            `CHECK(searching, 1'h0)
         end
         else
         begin
            step(3);
            `CHECK(outFreq, rows[i].expFreq + 16'h3)
         end
         runFwd = 1'h0;
         searchContact = 1'h0;
         wait_for(2, 20);
      end
      // run ahead of search: search stays ignored for this run
      code = speed_search_pkg::FUNC_SEARCH_FROM_MAX;
      method = speed_search_pkg::CTRL_VF_ENC;
      sel = 1'h1;
      encoderFitted = 1'h0;
      outputBlocked = 1'h0;
      decel = 7'h01;
      motorSpeed = MAXF - 16'h1;
      step(6);
      runFwd = 1'h1;
      wait_for(0, 20);
      `CHECK(outFreq, MINF)
      searchContact = 1'h1;
      step(8);
      `CHECK(searching, 1'h0)
      runFwd = 1'h0;
      searchContact = 1'h0;
      wait_for(2, 20);
      // search and reverse run together; held commands must not search again
      searchContact = 1'h1; // search raised with run
      runRev = 1'h1;
      wait_for(0, 20);
      `CHECK(searching, 1'h1)
      `CHECK(outFreq, MAXF)
      wait_for(1, 100);
      `CHECK(n, TICK + 1)
      `CHECK(outFreq, MAXF - 16'h1)
      step(1);
      `CHECK(speedAgree, 1'h0)
      step(9);
      `CHECK(searching, 1'h0)
      // threshold loads: top of range taken, one above refused
      thresholdIn = speed_search_pkg::THRESH_MAX_PCT;
      thresholdLoad = 1'h1;
      step(1);
      thresholdLoad = 1'h0;
      thresholdIn = 8'hC9;
      step(1);
      `CHECK(threshold, speed_search_pkg::THRESH_MAX_PCT)
      thresholdLoad = 1'h1;
      step(1);
      thresholdLoad = 1'h0;
      step(1);
      `CHECK(threshold, speed_search_pkg::THRESH_MAX_PCT)
      runRev = 1'h0;
      searchContact = 1'h0;
      wait_for(2, 20);
      // reset in mid-search, contacts released with it
      searchContact = 1'h1;
      runFwd = 1'h1;
      wait_for(0, 20);
      `CHECK(searching, 1'h1)
      rst_n = 1'h0;
      runFwd = 1'h0;
      searchContact = 1'h0;
      step(1);
      `CHECK(searching, 1'h0)
      `CHECK(outFreq, 16'h0000)
      `CHECK(threshold, speed_search_pkg::THRESH_DEF_VF)
      step(2);
      rst_n = 1'h1;
      step(2);
      `CHECK(outFreq, 16'h0000)
      `CHECK(speedAgree, 1'h0)
      `CHECK(searching, 1'h0)
      // first request after reset searches normally
      searchContact = 1'h1; // search raised with run
      runFwd = 1'h1;
      wait_for(0, 20);
      `CHECK(outFreq, MAXF)
      `CHECK(searching, 1'h1)
      conclude();
   end
endmodule // test_coasting_motor_speed_search
